// >>> hdl/clt_regs.svh
// Register offsets, reset values and sizes of the configurable logic tile
`ifndef CLT_REGS_SVH
`define CLT_REGS_SVH

`define CLT_ADDR_W          8
`define CLT_DATA_W          32

`define CLT_LUT_INPUTS      4
`define CLT_LUT_DEPTH       16
`define CLT_CELLS           4
`define CLT_SLICES          2

// Truth table or memory image of tables 0..3, one word each
`define CLT_OFS_LUT_BASE    8'h00
`define CLT_OFS_MODE        8'h10
`define CLT_OFS_SLICE_CFG   8'h14
`define CLT_OFS_STATUS      8'h18

// Two mode bits per table, table 0 in the low bits
`define CLT_MODE_W          2
// One sixteen-bit configuration half per slice, slice 0 low
`define CLT_SLICE_CFG_W     16

`define CLT_RST_LUT         16'h0000
`define CLT_RST_MODE        8'h00
`define CLT_RST_SLICE_CFG   16'h0000

// Status word: cell outputs in bits 3:0, storage elements in 7:4, carries in 9:8
`define CLT_STAT_CELL_LSB   0
`define CLT_STAT_Q_LSB      4
`define CLT_STAT_CARRY_LSB  8

`endif

// >>> hdl/clt_pkg.sv
// Types shared by the configurable logic tile
package clt_pkg;

  typedef enum logic [1:0] {
    CLT_LUT_LOGIC,
    CLT_LUT_RAM,
    CLT_LUT_SHIFT,
    CLT_LUT_SPARE
  } clt_lut_mode_e;

  typedef enum logic [1:0] {
    CLT_RAM_SINGLE,
    CLT_RAM_WIDE,
    CLT_RAM_DEEP,
    CLT_RAM_DUAL
  } clt_ram_combine_e;

  typedef struct packed {
    logic             and_gen;
    logic             xor_g;
    logic             xor_f;
    logic             inv_opp;
    logic             inv_init;
    logic             inv_ce;
    logic             inv_clk;
    logic             opp_async;
    logic             init_async;
    logic             init_g;
    logic             init_f;
    logic             dsel_g;
    logic             dsel_f;
    logic             latch;
    clt_ram_combine_e combine;
  } clt_slice_cfg_s;

  typedef struct packed {
    logic [3:0] f_addr;
    logic [3:0] g_addr;
    logic [1:0] direct;
    logic       slice_clk;
    logic       ce;
    logic       init_force;
    logic       opposite_force;
    logic       ram_we;
    logic       f5_sel;
    logic       carry_in;
  } clt_slice_in_s;

  typedef struct packed {
    logic [1:0] comb;
    logic [1:0] q;
    logic       f5;
    logic       carry_out;
  } clt_slice_out_s;

  typedef struct packed {
    logic data;
    logic oe;
  } clt_bus_drv_s;

endpackage

// >>> hdl/clt_logic_tile.sv
// Configurable logic tile: four cells in two slices, wide combiners, carry, bus drivers
`timescale 1ns/1ps
`include "clt_regs.svh"

// Operation
// - Cell has table, carry logic, storage element
// - Table output feeds tile output and flop
// - Four cells grouped as two slices
// - Table can be 16x1 synchronous RAM
// - Slice pair: 16x2, 32x1 or dual-port
// - Table can be 16-stage shift register
// - Storage element is flop or latch
// - Storage input from table or direct input
// - Init force loads configured initial state
// - Opposite force loads complement of initial state
// - Forces synchronous by default, optionally asynchronous
// - Clock, enable, forces invertible, shared per slice
// - Five-input combiner merges slice table outputs
// - Six-input combiner selects between five-input combiners
// - Four feedthrough paths, one per cell
// - Two carry chains, two bits each
// - Per-cell XOR gives one-bit full adder
// - Dedicated AND gate for partial products
// - Carry path cascades tables for wide functions
// - Two tristate bus drivers, own data and enable
module clt_logic_tile #(
  parameter int LUT_INPUTS = `CLT_LUT_INPUTS,
  parameter int CELLS      = `CLT_CELLS
) (
  input  wire logic                                  clk_sys,
  input  wire logic                                  sys_rst,
  input  wire logic [`CLT_ADDR_W-1:0]                reg_addr,
  input  wire logic [`CLT_DATA_W-1:0]                reg_wdata,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  output logic      [`CLT_DATA_W-1:0]                reg_rdata,
  input  wire clt_pkg::clt_slice_in_s [1:0]          slice_in,
  output clt_pkg::clt_slice_out_s     [1:0]          slice_out,
  input  wire logic                                  f6_sel,
  output logic                                       six_input_combiner,
  input  wire logic [3:0]                            ft_in,
  output logic      [3:0]                            ft_out,
  input  wire clt_pkg::clt_bus_drv_s  [1:0]          bus_drv_in,
  output clt_pkg::clt_bus_drv_s       [1:0]          tristate_bus_driver
);

  localparam logic [7:0] LUT_BASE = `CLT_OFS_LUT_BASE;

  if (LUT_INPUTS != 4 || CELLS != 4) begin : g_bad_size
    $error("clt_logic_tile only supports four-input tables and four cells");
  end
  // Both slice configurations share one data word
  if (`CLT_DATA_W < 2 * `CLT_SLICE_CFG_W) begin : g_bad_data_w
    $error("clt_logic_tile needs a data word that holds both slice configurations");
  end
  if (`CLT_LUT_DEPTH != (1 << LUT_INPUTS)) begin : g_bad_depth
    $error("clt_logic_tile table depth must match its input count");
  end
  if (`CLT_CELLS != 2 * `CLT_SLICES) begin : g_bad_slices
    $error("clt_logic_tile holds two cells per slice");
  end
  if (`CLT_MODE_W * CELLS > 8) begin : g_bad_mode_w
    $error("clt_logic_tile mode register holds one eight-bit word");
  end

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  function automatic logic tap(input logic [15:0] tbl, input logic [3:0] a);
    tap = tbl[a];
  endfunction

  // Clock, enable and both forces of a slice each have their own polarity bit
  function automatic logic ctl_level(input logic pin, input logic inv);
    ctl_level = pin ^ inv;
  endfunction

  // Cell 0 of a slice takes the F choice, cell 1 the G choice
  function automatic logic pick_fg(input int k, input logic f, input logic g);
    pick_fg = (k == 0) ? f : g;
  endfunction

  // Table storage doubles as truth table, RAM image and shift stages
  logic [15:0]                   lut_q [4];
  logic [7:0]                    mode_q;
  clt_pkg::clt_slice_cfg_s [1:0] cfg_q;
  logic [1:0]                    clk_prev_q;
  logic [3:0]                    ff_q;

  logic [3:0]                    lut_addr [4];
  logic [3:0]                    lut_wa [4];
  logic [3:0]                    lut_din;
  logic [3:0]                    lut_we;
  logic [3:0]                    shift_en;
  logic [3:0]                    lut_out;
  logic [3:0]                    cell_out;
  logic [3:0]                    ff_d;
  logic [3:0]                    ff_init;
  logic [1:0]                    carry_out;
  logic [1:0]                    f5;
  logic [1:0]                    clk_lvl;
  logic [1:0]                    clk_edge;
  logic [1:0]                    ce_on;
  logic [1:0]                    init_on;
  logic [1:0]                    opp_on;

  logic                          lut_reg_hit;
  logic [1:0]                    lut_reg_idx;

  assign lut_reg_hit = (reg_addr[7:4] == LUT_BASE[7:4]) && (reg_addr[1:0] == 2'h0);
  assign lut_reg_idx = reg_addr[3:2];

  // Edge uses the previous raw pin under the current polarity, so a polarity
  // change on a steady pin never fakes a slice edge
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      clk_lvl[s]  = ctl_level(slice_in[s].slice_clk, cfg_q[s].inv_clk);
      clk_edge[s] = clk_lvl[s] & ~ctl_level(clk_prev_q[s], cfg_q[s].inv_clk);
      ce_on[s]    = ctl_level(slice_in[s].ce, cfg_q[s].inv_ce);
      init_on[s]  = ctl_level(slice_in[s].init_force, cfg_q[s].inv_init);
      opp_on[s]   = ctl_level(slice_in[s].opposite_force, cfg_q[s].inv_opp);
    end
  end

  always_comb begin
    clt_pkg::clt_slice_cfg_s cfg;
    clt_pkg::clt_slice_in_s  in;
    logic                    c;
    logic                    gen;
    logic                    ram_we;
    int                      i;
    cfg = '0;
    in  = '0;
    c   = 1'b0;
    gen = 1'b0;
    ram_we = 1'b0;
    i   = 0;
    for (int s = 0; s < 2; s++) begin
      cfg = cfg_q[s];
      in  = slice_in[s];

      lut_addr[2*s]   = in.f_addr;
      lut_addr[2*s+1] = in.g_addr;
      lut_wa[2*s]     = in.f_addr;
      lut_wa[2*s+1]   = in.f_addr;
      lut_din[2*s]    = in.direct[0];
      lut_din[2*s+1]  = in.direct[0];
      ram_we          = clk_edge[s] & in.ram_we;
      lut_we[2*s]     = ram_we;
      lut_we[2*s+1]   = ram_we;
      case (cfg.combine)
        clt_pkg::CLT_RAM_SINGLE: begin
          lut_wa[2*s+1]  = in.g_addr;
          lut_din[2*s+1] = in.direct[1];
        end
        clt_pkg::CLT_RAM_WIDE: begin
          // Two bits per word share one address
          lut_addr[2*s+1] = in.f_addr;
          lut_din[2*s+1]  = in.direct[1];
        end
        clt_pkg::CLT_RAM_DEEP: begin
          // Fifth address bit picks the half and reads through the combiner
          lut_addr[2*s+1] = in.f_addr;
          lut_we[2*s]     = ram_we & ~in.f5_sel;
          lut_we[2*s+1]   = ram_we & in.f5_sel;
        end
        clt_pkg::CLT_RAM_DUAL: begin
          // Both copies written alike; second table reads at its own address
          lut_addr[2*s+1] = in.g_addr;
        end
        default: begin
          lut_we[2*s+1] = ram_we;
        end
      endcase
      shift_en[2*s]   = clk_edge[s] & ce_on[s];
      shift_en[2*s+1] = clk_edge[s] & ce_on[s];
      if (cfg.combine == clt_pkg::CLT_RAM_SINGLE) begin
        lut_din[2*s+1] = in.direct[1];
      end

      c = in.carry_in;
      for (int k = 0; k < 2; k++) begin
        i = 2 * s + k;
        lut_out[i] = tap(lut_q[i], lut_addr[i]);
        // Partial product of the two low operand bits
        gen = cfg.and_gen ? (lut_addr[i][0] & lut_addr[i][1]) : in.direct[k];
        cell_out[i] = pick_fg(k, cfg.xor_f, cfg.xor_g) ? (lut_out[i] ^ c) : lut_out[i];
        ff_d[i] = pick_fg(k, cfg.dsel_f, cfg.dsel_g) ? in.direct[k] : cell_out[i];
        ff_init[i] = pick_fg(k, cfg.init_f, cfg.init_g);
        // Table output propagates, otherwise generate; also cascades wide functions
        c = lut_out[i] ? c : gen;
      end
      carry_out[s] = c;
      f5[s] = in.f5_sel ? lut_out[2*s+1] : lut_out[2*s];
    end
  end

  // Software load of a table wins over a user write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        lut_q[i] <= `CLT_RST_LUT;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (reg_wr && lut_reg_hit && lut_reg_idx == 2'(i)) begin
          lut_q[i] <= reg_wdata[15:0];
        end else begin
          case (clt_pkg::clt_lut_mode_e'(mode_q[2*i +: 2]))
            clt_pkg::CLT_LUT_RAM: begin
              if (lut_we[i]) begin
                lut_q[i][lut_wa[i]] <= lut_din[i];
              end
            end
            clt_pkg::CLT_LUT_SHIFT: begin
              if (shift_en[i]) begin
                lut_q[i] <= {lut_q[i][14:0], lut_din[i]};
              end
            end
            default: begin
              lut_q[i] <= lut_q[i];
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_q <= `CLT_RST_MODE;
    end else if (reg_wr && reg_hit(reg_addr, `CLT_OFS_MODE)) begin
      mode_q <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_q <= {`CLT_RST_SLICE_CFG, `CLT_RST_SLICE_CFG};
    end else if (reg_wr && reg_hit(reg_addr, `CLT_OFS_SLICE_CFG)) begin
      cfg_q <= reg_wdata[31:0];
    end
  end

  // Raw pins kept, polarity applied when the edge is formed
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clk_prev_q <= 2'h0;
    end else begin
      clk_prev_q <= {slice_in[1].slice_clk, slice_in[0].slice_clk};
    end
  end

  // Storage elements: init force over opposite force over data
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ff_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (init_on[i/2] && (cfg_q[i/2].init_async || clk_edge[i/2])) begin
          ff_q[i] <= ff_init[i];
        end else if (opp_on[i/2] && (cfg_q[i/2].opp_async || clk_edge[i/2])) begin
          ff_q[i] <= ~ff_init[i];
        end else if (cfg_q[i/2].latch ? (clk_lvl[i/2] && ce_on[i/2]) : (clk_edge[i/2] && ce_on[i/2])) begin
          ff_q[i] <= ff_d[i];
        end
      end
    end
  end

  // Every user-facing output is registered on the system clock
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      slice_out <= '0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        slice_out[s].comb      <= cell_out[2*s +: 2];
        slice_out[s].q         <= ff_q[2*s +: 2];
        slice_out[s].f5        <= f5[s];
        slice_out[s].carry_out <= carry_out[s];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      six_input_combiner <= 1'b0;
    end else begin
      six_input_combiner <= f6_sel ? f5[1] : f5[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ft_out <= 4'h0;
    end else begin
      ft_out <= ft_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tristate_bus_driver <= '0;
    end else begin
      tristate_bus_driver <= bus_drv_in;
    end
  end

  logic [`CLT_DATA_W-1:0]        rdata_d;

  // Read data stand one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      if (lut_reg_hit) begin
        rdata_d[15:0] = lut_q[lut_reg_idx];
      end else if (reg_hit(reg_addr, `CLT_OFS_MODE)) begin
        rdata_d[7:0] = mode_q;
      end else if (reg_hit(reg_addr, `CLT_OFS_SLICE_CFG)) begin
        rdata_d = cfg_q;
      end else if (reg_hit(reg_addr, `CLT_OFS_STATUS)) begin
        rdata_d[`CLT_STAT_CELL_LSB +: 4]  = cell_out;
        rdata_d[`CLT_STAT_Q_LSB +: 4]     = ff_q;
        rdata_d[`CLT_STAT_CARRY_LSB +: 2] = carry_out;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

// >>> verif/clt_bus_line.sv
// Shared bus line driven by the tile's two tristate drivers
`timescale 1ns/1ps
module clt_bus_line (
  input  wire logic                       clk_sys,
  input  wire clt_pkg::clt_bus_drv_s [1:0] drv,
  output logic                            line
);
  logic last_q = 1'h0;
  // No keeper: a released line must not look like the last driven value
  always_comb begin
    if (drv[0].oe) begin
      line = drv[0].data;
    end else if (drv[1].oe) begin
      line = drv[1].data;
    end else begin
      line = ~last_q;
    end
  end
  always_ff @(posedge clk_sys) begin
    last_q <= line;
  end
endmodule

// >>> verif/clt_tile_checker.sv
// Port checker for the configurable logic tile
`timescale 1ns/1ps
`include "clt_regs.svh"
module clt_tile_checker #(
  parameter int LUT_INPUTS = 4,
  parameter int CELLS      = 4
) (
  input wire logic                          clk_sys,
  input wire logic                          sys_rst,
  input wire logic [`CLT_ADDR_W-1:0]        reg_addr,
  input wire logic [`CLT_DATA_W-1:0]        reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [`CLT_DATA_W-1:0]        reg_rdata,
  input wire clt_pkg::clt_slice_in_s [1:0]  slice_in,
  input wire clt_pkg::clt_slice_out_s [1:0] slice_out,
  input wire logic                          f6_sel,
  input wire logic                          six_input_combiner,
  input wire logic [3:0]                    ft_in,
  input wire logic [3:0]                    ft_out,
  input wire clt_pkg::clt_bus_drv_s [1:0]   bus_drv_in,
  input wire clt_pkg::clt_bus_drv_s [1:0]   tristate_bus_driver
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence wr_then_rd(a);
    reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
  endsequence
  property readback(a, m);
    wr_then_rd(a) |=> (reg_rdata & m) == ($past(reg_wdata, 2) & m);
  endproperty
  feed_through_a: assert property (!$past(sys_rst) |-> ft_out == $past(ft_in))
    else $error("feedthrough output wrong");
  bus_driver_a: assert property (!$past(sys_rst) |-> tristate_bus_driver == $past(bus_drv_in))
    else $error("bus driver output wrong");
  six_combine_a: assert property (!$past(sys_rst) |->
    six_input_combiner == ($past(f6_sel) ? slice_out[1].f5 : slice_out[0].f5))
    else $error("six input combiner picked wrong slice");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read slot");
  unmapped_read_a: assert property ($past(reg_rd) && $past(reg_addr) > 8'h18 |-> reg_rdata == '0)
    else $error("unmapped read not zero");
  reset_clear_a: assert property ($fell(sys_rst) |-> ft_out == 4'h0 && slice_out == '0
    && tristate_bus_driver == '0 && !six_input_combiner)
    else $error("outputs not cleared by reset");
  mode_readback_a: assert property (readback(8'h10, 32'h0000_00ff))
    else $error("mode readback wrong");
  cfg_readback_a: assert property (readback(8'h14, 32'hffff_ffff))
    else $error("slice config readback wrong");
endmodule
bind clt_logic_tile clt_tile_checker #(.LUT_INPUTS(LUT_INPUTS), .CELLS(CELLS)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slice_in(slice_in),
  .slice_out(slice_out), .f6_sel(f6_sel), .six_input_combiner(six_input_combiner),
  .ft_in(ft_in), .ft_out(ft_out), .bus_drv_in(bus_drv_in),
  .tristate_bus_driver(tristate_bus_driver));

// >>> verif/testbench.sv
// Self-checking testbench for the configurable logic tile
`timescale 1ns/1ps
module testbench;
  logic                         clk_sys = 1'h0;
  logic                         sys_rst = 1'h1;
  logic [7:0]                   reg_addr = 8'h00;
  logic [31:0]                  reg_wdata = 32'h0, reg_rdata;
  logic                         reg_wr = 1'h0, reg_rd = 1'h0;
  clt_pkg::clt_slice_in_s [1:0]  slice_in = '0;
  clt_pkg::clt_slice_out_s [1:0] slice_out;
  logic                         f6_sel = 1'h0, six;
  logic [3:0]                   ft_in = 4'h0, ft_out;
  clt_pkg::clt_bus_drv_s [1:0]   bus_drv_in = '0, bus_drv;
  logic                         line;
  int                           n_fail = 0, total_checks = 0;

  clt_logic_tile i_clt_logic_tile (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .slice_in(slice_in), .slice_out(slice_out), .f6_sel(f6_sel), .six_input_combiner(six),
    .ft_in(ft_in), .ft_out(ft_out), .bus_drv_in(bus_drv_in), .tristate_bus_driver(bus_drv));
  clt_bus_line u_line (.clk_sys(clk_sys), .drv(bus_drv), .line(line));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
    @(posedge clk_sys) reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk_sys) {reg_rd, reg_addr} <= {1'h1, a};
    @(posedge clk_sys) reg_rd <= 1'h0;
    #1 chk(nm, exp, reg_rdata);
  endtask
  // Write then read with no gap between strobes
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp, input string nm);
    wr(a, d);
    reg_rd <= 1'h1;
    @(posedge clk_sys) reg_rd <= 1'h0;
    #1 chk(nm, exp, reg_rdata);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // One slice clock pulse, then wait for the copied storage outputs
  task automatic pulse;
    @(posedge clk_sys) slice_in[0].slice_clk <= 1'h1;
    @(posedge clk_sys) slice_in[0].slice_clk <= 1'h0;
    settle();
  endtask
  task automatic s_regs;
    for (int i = 0; i < 4; i++) rd(8'(i * 4), 32'h0, "table reset");
    rd(8'h14, 32'h0, "cfg reset");
    wr_rd(8'h10, 32'h0000_00e4, 32'h0000_00e4, "mode rw");
    wr_rd(8'h14, 32'h1234_5678, 32'h1234_5678, "cfg rw");
    wr_rd(8'h20, 32'hffff_ffff, 32'h0, "unmapped");
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0);
  endtask
  task automatic s_ram;
    wr(8'h10, 32'h1);
    @(posedge clk_sys) {slice_in[0].f_addr, slice_in[0].direct, slice_in[0].ram_we} <= {4'h3, 2'h1, 1'h1};
    pulse();
    chk("ram read bit3", 32'h1, slice_out[0].comb[0]);
    @(posedge clk_sys) {slice_in[0].f_addr, slice_in[0].ram_we} <= {4'h4, 1'h0};
    settle();
    chk("ram read bit4", 32'h0, slice_out[0].comb[0]);
    rd(8'h00, 32'h0000_0008, "ram image");
  endtask
  task automatic s_shift;
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h2);
    @(posedge clk_sys) slice_in[0].ce <= 1'h1;
    pulse();
    @(posedge clk_sys) slice_in[0].direct <= 2'h0;
    pulse();
    pulse();
    @(posedge clk_sys) slice_in[0].ce <= 1'h0;
    pulse();
    rd(8'h00, 32'h0000_0004, "shift image");
    @(posedge clk_sys) {slice_in[0].f_addr, slice_in[0].ce} <= {4'h2, 1'h1};
    settle();
    chk("shift tap", 32'h1, slice_out[0].comb[0]);
  endtask
  task automatic s_store;
    wr(8'h00, 32'h0000_ffff);
    wr(8'h10, 32'h0);
    pulse();
    chk("cell out", 32'h1, slice_out[0].comb[0]);
    chk("flop", 32'h1, slice_out[0].q[0]);
    @(posedge clk_sys) slice_in[0].init_force <= 1'h1;
    settle();
    chk("sync init idle", 32'h1, slice_out[0].q[0]);
    pulse();
    chk("init force", 32'h0, slice_out[0].q[0]);
    @(posedge clk_sys) {slice_in[0].init_force, slice_in[0].opposite_force} <= 2'h1;
    pulse();
    chk("opposite force", 32'h1, slice_out[0].q[0]);
    @(posedge clk_sys) slice_in[0].opposite_force <= 1'h0;
    wr(8'h14, 32'h0000_0080);
    @(posedge clk_sys) slice_in[0].init_force <= 1'h1;
    settle();
    chk("async init", 32'h0, slice_out[0].q[0]);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys) {slice_in[0].f5_sel, f6_sel} <= 2'(i);
      settle();
      chk("six combiner", 32'(i == 0), six);
    end
  endtask
  // Both cells propagate, so carry in reaches carry out and flips the sum
  task automatic s_carry;
    wr(8'h04, 32'h0000_ffff);
    wr(8'h14, 32'h0000_2000);
    for (int c = 0; c < 2; c++) begin
      @(posedge clk_sys) slice_in[0].carry_in <= 1'(c);
      settle();
      chk("carry out", 32'(c), slice_out[0].carry_out);
      chk("xor sum", 32'(c == 0), slice_out[0].comb[0]);
    end
  endtask
  task automatic s_wires;
    @(posedge clk_sys) {ft_in, bus_drv_in} <= {4'ha, 4'hc};
    settle();
    chk("feedthrough", 32'ha, ft_out);
    chk("bus line hi", 32'h1, line);
    @(posedge clk_sys) bus_drv_in <= 4'h1;
    settle();
    chk("bus line lo", 32'h0, line);
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'h0;
    s_regs();
    s_ram();
    s_shift();
    s_store();
    s_carry();
    s_wires();
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end
endmodule
